/* File: rtl/isdn_tdm_cfg.svh */
// Constants for the link slot interface: offsets, fields, resets, frame layout, timing
`ifndef ISDN_TDM_CFG_SVH
`define ISDN_TDM_CFG_SVH

// ----------------------------------------------------------------
// Register map: byte address = {channel, register index}
// ----------------------------------------------------------------
`define REG_CTRL         2'h0
`define REG_MASK         2'h1
`define REG_TX_DATA      2'h2
`define REG_RX_DATA      2'h3
`define ADDR_CHAN_BIT    2
`define ADDR_UNMAPPED    3

// ----------------------------------------------------------------
// Control/status register fields
// ----------------------------------------------------------------
`define CTRL_SEL_LSB     0
`define CTRL_SEL_MSB     1
`define CTRL_TRANSP      2
`define CTRL_IDLE_ONE    3
`define CTRL_TX_EN       4
`define STAT_TX_FULL     5
`define STAT_RX_FULL     6
`define STAT_RX_OVR      7

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_CTRL         5'h00
`define RST_MASK         8'h00
`define RST_TX_DATA      8'hFF

// ----------------------------------------------------------------
// Frame layout, bit numbers 1..20
// ----------------------------------------------------------------
`define FRAME_BITS       5'd20
`define POS_ARMED        5'd0
`define POS_IDLE         5'd21
`define BEARER_ONE_FIRST 5'd1
`define BEARER_ONE_LAST  5'd8
`define D_BIT_FIRST      5'd9
`define BEARER_TWO_FIRST 5'd11
`define BEARER_TWO_LAST  5'd18
`define D_BIT_SECOND     5'd19

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define FRAME_PERIOD_US  125
`define CLK_PERIOD_NS    5
`define FRAME_CYCLES     ((`FRAME_PERIOD_US * 1000) / `CLK_PERIOD_NS)

`endif

/* File: rtl/isdn_tdm_pkg.sv */
// Types and slot decode helpers for the link slot interface
`include "isdn_tdm_cfg.svh"

package isdn_tdm_pkg;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SEL_OFF,
    SEL_BEARER_ONE,
    SEL_BEARER_TWO,
    SEL_D
  } slot_sel_t;

  typedef struct packed {
    logic      tx_enable;
    logic      idle_one;
    logic      transparent;
    slot_sel_t slot_sel;
  } chan_ctrl_t;

  typedef struct packed {
    logic       hit;
    logic [2:0] idx;
  } slot_hit_t;

  // ----------------------------------------------------------------
  // Which channel bit a frame position carries, if any
  // ----------------------------------------------------------------
  function automatic slot_hit_t slot_decode(input slot_sel_t sel, input logic [4:0] pos);
    slot_hit_t r;
    r = '0;
    case (sel)
      SEL_BEARER_ONE: begin
        r.hit = (pos >= `BEARER_ONE_FIRST) && (pos <= `BEARER_ONE_LAST);
        r.idx = 3'(pos - `BEARER_ONE_FIRST);
      end
      SEL_BEARER_TWO: begin
        r.hit = (pos >= `BEARER_TWO_FIRST) && (pos <= `BEARER_TWO_LAST);
        r.idx = 3'(pos - `BEARER_TWO_FIRST);
      end
      SEL_D: begin
        r.hit = (pos == `D_BIT_FIRST) || (pos == `D_BIT_SECOND);
        r.idx = (pos == `D_BIT_SECOND) ? 3'h1 : 3'h0;
      end
      default: r = '0;
    endcase
    return r;
  endfunction : slot_decode

  // ----------------------------------------------------------------
  // Slot bit that closes a transparent byte, from the single zero
  // ----------------------------------------------------------------
  function automatic logic [2:0] byte_end_idx(input logic [7:0] mask);
    logic [2:0] align;
    align = 3'h0;
    for (int i = 0; i < 8; i++) begin
      if (!mask[i]) begin
        align = 3'(7 - i);
      end
    end
    // The seventh slot bit opens the byte for zero alignment, so the
    // byte closes one slot bit before that
    return 3'(align + 3'h5);
  endfunction : byte_end_idx

endpackage : isdn_tdm_pkg

/* File: rtl/isdn_tdm_slot_interface.sv */
// Two-channel serial slot interface for the 20-bit interchip link frame

module isdn_tdm_slot_interface
  import isdn_tdm_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_ce,
  input  wire logic [3:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  input  wire logic       i_link_bit_clock,
  input  wire logic       i_link_frame_sync,
  input  wire logic       i_link_rx_in,
  input  wire logic       i_d_channel_grant,
  output logic            o_link_tx_out,
  output logic            o_link_tx_oe_n,
  output logic            o_d_channel_request
);

  // ----------------------------------------------------------------
  // Pin synchronisers and bit clock edge detect
  // ----------------------------------------------------------------
  logic [3:0] pin_meta;
  logic [3:0] pin_sync;
  logic       clk_last;
  logic       clk_now;
  logic       sync_now;
  logic       rx_now;
  logic       grant_now;
  logic       bit_rise;
  logic       bit_fall;

  // Two stages on every pin; only the second stage feeds logic
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pin_meta <= 4'h0;
      pin_sync <= 4'h0;
      clk_last <= 1'b0;
    end else if (i_ce) begin
      pin_meta <= {i_d_channel_grant, i_link_rx_in, i_link_frame_sync, i_link_bit_clock};
      pin_sync <= pin_meta;
      clk_last <= pin_sync[0];
    end
  end

  assign clk_now   = pin_sync[0];
  assign sync_now  = pin_sync[1];
  assign rx_now    = pin_sync[2];
  assign grant_now = pin_sync[3];
  assign bit_rise  = i_ce & clk_now & ~clk_last;   // Transmit launch edge
  assign bit_fall  = i_ce & ~clk_now & clk_last;   // Receive sample edge

  // ----------------------------------------------------------------
  // Frame bit position
  // ----------------------------------------------------------------
  logic [4:0] pos;
  logic [4:0] next_pos;

  // Sync sampled mid-period arms the count; stops at idle after bit 20
  assign next_pos = (pos == `POS_IDLE) ? `POS_IDLE : 5'(pos + 5'd1);

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pos <= `POS_IDLE;
    end else if (bit_fall && sync_now) begin
      pos <= `POS_ARMED;
    end else if (bit_rise) begin
      pos <= next_pos;
    end
  end

  // ----------------------------------------------------------------
  // Per-channel registers and shifters
  // ----------------------------------------------------------------
  chan_ctrl_t ctrl      [2];
  logic [7:0] mask      [2];
  logic [7:0] tx_hold   [2];
  logic       tx_full   [2];
  logic [7:0] rx_data   [2];
  logic       rx_full   [2];
  logic       rx_ovr    [2];
  logic [7:0] rx_sr     [2];
  logic [7:0] tx_sr     [2];
  logic [2:0] bit_cnt   [2];
  logic       byte_sync [2];
  logic       tx_drive  [2];
  logic       tx_bit    [2];
  logic       d_want    [2];

  genvar c;
  generate
    for (c = 0; c < 2; c++) begin : g_chan
      slot_hit_t rx_hit;
      slot_hit_t tx_hit;
      logic      bearer;
      logic      transp;
      logic      rx_masked;
      logic      tx_masked;
      logic      rx_take;
      logic      tx_slot;
      logic      sel_me;
      logic      wr_me;
      logic      rd_me;

      assign sel_me = (i_addr[`ADDR_CHAN_BIT] == 1'(c)) && !i_addr[`ADDR_UNMAPPED];
      assign wr_me  = i_ce & i_wr & sel_me;
      assign rd_me  = i_ce & i_rd & sel_me;

      // Slot decode for the bit being sampled and for the bit about to launch
      assign rx_hit = slot_decode(ctrl[c].slot_sel, pos);
      assign tx_hit = slot_decode(ctrl[c].slot_sel, next_pos);
      assign bearer = (ctrl[c].slot_sel == SEL_BEARER_ONE) ||
                      (ctrl[c].slot_sel == SEL_BEARER_TWO);
      // Transparent request is refused on the D-channel
      assign transp = ctrl[c].transparent & bearer;
      // Mask gates bits only in framed bearer use; transparent uses it as alignment
      assign rx_masked = bearer & ~transp & mask[c][rx_hit.idx];
      assign tx_masked = bearer & ~transp & mask[c][tx_hit.idx];
      assign rx_take   = bit_fall & rx_hit.hit & ~rx_masked;
      // Byte sync fires on the falling edge, half a bit past the slot boundary
      assign byte_sync[c] = rx_take &
        (transp ? (rx_hit.idx == byte_end_idx(mask[c])) : (bit_cnt[c] == 3'h7));
      // D bits go out only while the transceiver grants the channel
      assign tx_slot = tx_hit.hit & ctrl[c].tx_enable &
                       ((ctrl[c].slot_sel != SEL_D) | grant_now);
      assign tx_drive[c] = bit_rise & tx_slot & (~tx_masked | ctrl[c].idle_one);
      assign tx_bit[c]   = tx_masked ? 1'b1 : tx_sr[c][0];
      assign d_want[c]   = (ctrl[c].slot_sel == SEL_D) & ctrl[c].tx_enable & tx_full[c];

      // Control and mask registers
      always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
          ctrl[c] <= `RST_CTRL;
          mask[c] <= `RST_MASK;
        end else if (wr_me && i_addr[1:0] == `REG_CTRL) begin
          ctrl[c] <= i_wdata[`CTRL_TX_EN:`CTRL_SEL_LSB];
        end else if (wr_me && i_addr[1:0] == `REG_MASK) begin
          mask[c] <= i_wdata;
        end
      end

      // Transmit holding byte; a software write beats the sync that empties it
      always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
          tx_hold[c] <= `RST_TX_DATA;
          tx_full[c] <= 1'b0;
        end else if (wr_me && i_addr[1:0] == `REG_TX_DATA) begin
          tx_hold[c] <= i_wdata;
          tx_full[c] <= 1'b1;
        end else if (byte_sync[c]) begin
          tx_full[c] <= 1'b0;
        end
      end

      // Receive shifter, LSB first; completed bytes land in the data register
      always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
          rx_sr[c]   <= 8'h00;
          rx_data[c] <= 8'h00;
          bit_cnt[c] <= 3'h0;
        end else if (rx_take) begin
          rx_sr[c]   <= {rx_now, rx_sr[c][7:1]};
          bit_cnt[c] <= byte_sync[c] ? 3'h0 : 3'(bit_cnt[c] + 3'h1);
          if (byte_sync[c]) begin
            rx_data[c] <= {rx_now, rx_sr[c][7:1]};
          end
        end
      end

      // Receive flags; the hardware set wins over a clearing read
      always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
          rx_full[c] <= 1'b0;
          rx_ovr[c]  <= 1'b0;
        end else if (byte_sync[c]) begin
          rx_full[c] <= 1'b1;
          rx_ovr[c]  <= rx_ovr[c] | (rx_full[c] & ~(rd_me && i_addr[1:0] == `REG_RX_DATA));
        end else if (rd_me && i_addr[1:0] == `REG_RX_DATA) begin
          rx_full[c] <= 1'b0;
          rx_ovr[c]  <= 1'b0;
        end
      end

      // Transmit shifter: reload on sync, shift one bit per active launch.
      // An empty holding register sends all ones rather than stale data.
      always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
          tx_sr[c] <= `RST_TX_DATA;
        end else if (byte_sync[c]) begin
          tx_sr[c] <= tx_full[c] ? tx_hold[c] : `RST_TX_DATA;
        end else if (bit_rise && tx_slot && !tx_masked) begin
          tx_sr[c] <= {1'b1, tx_sr[c][7:1]};
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Shared link pins
  // ----------------------------------------------------------------
  // Channel 0 takes the pin if both claim a bit; software keeps them apart
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_link_tx_out  <= 1'b1;
      o_link_tx_oe_n <= 1'b1;
    end else if (bit_rise) begin
      o_link_tx_oe_n <= ~(tx_drive[0] | tx_drive[1]);
      o_link_tx_out  <= tx_drive[0] ? tx_bit[0] : (tx_drive[1] ? tx_bit[1] : 1'b1);
    end
  end

  // D-channel request while a byte waits to go out
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_d_channel_request <= 1'b0;
    end else if (i_ce) begin
      o_d_channel_request <= d_want[0] | d_want[1];
    end
  end

  // ----------------------------------------------------------------
  // Register read port, data one cycle after the strobe
  // ----------------------------------------------------------------
  logic ch;
  assign ch = i_addr[`ADDR_CHAN_BIT];

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= 8'h00;
    end else if (i_ce) begin
      o_rdata <= 8'h00;
      if (i_rd && !i_addr[`ADDR_UNMAPPED]) begin
        case (i_addr[1:0])
          `REG_CTRL:    o_rdata <= {rx_ovr[ch], rx_full[ch], tx_full[ch], ctrl[ch]};
          `REG_MASK:    o_rdata <= mask[ch];
          `REG_TX_DATA: o_rdata <= tx_hold[ch];
          `REG_RX_DATA: o_rdata <= rx_data[ch];
          default:      o_rdata <= 8'h00;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Alias so the D-channel check reads a plain net, not a hierarchical one
  logic rx_take_d0;
  assign rx_take_d0 = g_chan[0].rx_take;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  sequence s_sync_seen;
    bit_fall && sync_now;
  endsequence

  sequence s_first_launch;
    bit_rise && pos == `POS_ARMED;
  endsequence

  a_pos_resync: assert property (s_sync_seen |=> pos == `POS_ARMED)
    else $error("bit position not rearmed by frame sync");

  a_pos_advance: assert property (s_sync_seen ##[1:200] s_first_launch |=> pos == 5'd1)
    else $error("first rising edge after sync is not bit one");

  a_frame_stop: assert property (bit_rise && pos == `FRAME_BITS && !(bit_fall && sync_now)
                                  |=> pos == `POS_IDLE)
    else $error("bit position ran past twenty");

  a_tx_float_spare: assert property (bit_rise && (next_pos == 5'd10 || next_pos == 5'd20 ||
                                     next_pos == `POS_IDLE) |=> o_link_tx_oe_n)
    else $error("transmit pin driven on an unassigned bit");

  a_rx_ignore: assert property (bit_fall && !g_chan[0].rx_hit.hit
                                |=> $stable(rx_sr[0]))
    else $error("receiver took a bit outside its slot");

  a_mask_idle_one: assert property (bit_rise && g_chan[0].tx_slot && g_chan[0].tx_masked &&
                                    ctrl[0].idle_one
                                    |=> !o_link_tx_oe_n && o_link_tx_out)
    else $error("masked bit not driven as idle one");

  a_mask_d_off: assert property (ctrl[0].slot_sel == SEL_D && ctrl[0].transparent &&
                                 rx_take_d0 |-> byte_sync[0] == (bit_cnt[0] == 3'h7))
    else $error("transparent sync used on the D-channel");

  a_d_channel_request_follow: assert property (d_want[0] |-> ##1 o_d_channel_request)
    else $error("D-channel request missing while data waits");

  a_sync_half_bit: assert property (byte_sync[0] |-> bit_fall)
    else $error("byte sync outside the falling bit edge");

  // A completed byte must always be offered to software
  a_rx_store: assert property (byte_sync[0] |=> rx_full[0])
    else $error("completed receive byte not flagged");

  // The sync takes the waiting byte unless software refills it in that cycle
  a_tx_hold_take: assert property (byte_sync[0] && tx_full[0] &&
                                   !(g_chan[0].wr_me && i_addr[1:0] == `REG_TX_DATA)
                                   |=> !tx_full[0])
    else $error("transmit holding byte not taken at byte sync");

  // Masked bearer bits never reach the receive shifter
  a_mask_rx_skip: assert property (bit_fall && g_chan[0].rx_hit.hit && g_chan[0].rx_masked
                                   |=> $stable(rx_sr[0]))
    else $error("receiver took a masked bit");

  // Without grant a lone D-channel user leaves the pin released
  a_no_grant_float: assert property (bit_rise && !grant_now && ctrl[1].slot_sel == SEL_D &&
                                     ctrl[0].slot_sel == SEL_OFF
                                     |=> o_link_tx_oe_n)
    else $error("D bit driven without grant");

endmodule : isdn_tdm_slot_interface

/* File: tb/isdn_tdm_master_model.sv */
// Behavioural link master: bit clock, frame sync, receive data, grant and capture
module isdn_tdm_master_model #(
  parameter int FRAME_CLKS = 24
) (
  input  wire logic        i_link_tx_out,
  input  wire logic        i_link_tx_oe_n,
  input  wire logic        i_grant_enable,
  input  wire logic [19:0] i_rx_frame,
  output logic             o_link_bit_clock,
  output logic             o_link_frame_sync,
  output logic             o_link_rx_in,
  output logic             o_d_channel_grant,
  output logic      [19:0] o_tx_seen,
  output logic      [19:0] o_oe_seen,
  output int               o_frame_count
);
  timeunit 1ns;
  timeprecision 100ps;

  int bit_pos;

  // Continuous bit clock, offset so its edges never line up with the system clock
  initial begin
    o_link_bit_clock = 1'b0;
    #1.3;
    forever #62.5 o_link_bit_clock = ~o_link_bit_clock;
  end

  // Quiet lines until the first frame starts
  initial begin
    bit_pos = 0;
    o_link_frame_sync = 1'b0;
    o_link_rx_in = 1'b0;
    o_d_channel_grant = 1'b0;
    o_tx_seen = 20'h0_0000;
    o_oe_seen = 20'h0_0000;
    o_frame_count = 0;
  end

  // Launch on rising edges: sync one period before bit 1, then twenty bits
  always @(posedge o_link_bit_clock) begin
    bit_pos = (bit_pos == FRAME_CLKS - 1) ? 0 : bit_pos + 1;
    o_link_frame_sync <= (bit_pos == 0);
    o_d_channel_grant <= i_grant_enable;
    if (bit_pos >= 1 && bit_pos <= 20) begin
      o_link_rx_in <= i_rx_frame[bit_pos - 1];
    end else begin
      o_link_rx_in <= ~o_link_rx_in; // Junk outside the frame must be ignored
    end
  end

  // Sample on falling edges; a released line reads as the pull-up level
  always @(negedge o_link_bit_clock) begin
    if (bit_pos >= 1 && bit_pos <= 20) begin
      o_tx_seen[bit_pos - 1] <= i_link_tx_oe_n ? 1'b1 : i_link_tx_out;
      o_oe_seen[bit_pos - 1] <= ~i_link_tx_oe_n;
    end
    if (bit_pos == 20) begin
      o_frame_count <= o_frame_count + 1;
    end
  end
endmodule : isdn_tdm_master_model

/* File: tb/isdn_tdm_slot_interface_tb.sv */
// Self-checking bench for the two-channel link slot interface
`include "isdn_tdm_cfg.svh"
`define CHK(what, exp, got) \
  begin \
    cmp_count++; \
    if ((got) !== (exp)) begin \
      mismatches++; \
      $display("MISMATCH %s expected %h seen %h", what, exp, got); \
    end \
  end

module isdn_tdm_slot_interface_tb;
  timeunit 1ns;
  timeprecision 100ps;

  typedef struct packed {
    logic [19:0] oe;
    logic [19:0] tx;
    logic [19:0] chk;
  } frame_exp_t;

  logic        i_clk    = 1'b0;
  logic        i_rst    = 1'b1;
  logic [3:0]  i_addr   = 4'h0;
  logic [7:0]  i_wdata  = 8'h00;
  logic        i_wr     = 1'b0;
  logic        i_rd     = 1'b0;
  logic        grant_en = 1'b0;
  logic [19:0] rx_frame = 20'h0_0000;
  logic        rd_seen  = 1'b0;
  logic [7:0]  o_rdata, rd_exp;
  logic        bclk, fsync, rxd, grant, txd, txoe_n, d_channel_request;
  logic [19:0] tx_seen, oe_seen;
  int          frame_count;
  int          mismatches = 0;
  int          cmp_count  = 0;
  int          seed       = 67983;
  logic [7:0]  rd_q[$];
  frame_exp_t  fr_q[$];
  frame_exp_t  fe;

  always #2.5 i_clk = ~i_clk;

  isdn_tdm_slot_interface isdn_tdm_slot_interface_i (
    .i_clk(i_clk), .i_rst(i_rst), .i_ce(1'b1), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_link_bit_clock(bclk),
    .i_link_frame_sync(fsync), .i_link_rx_in(rxd), .i_d_channel_grant(grant),
    .o_link_tx_out(txd), .o_link_tx_oe_n(txoe_n), .o_d_channel_request(d_channel_request));

  isdn_tdm_master_model isdn_tdm_master_model_i (
    .i_link_tx_out(txd), .i_link_tx_oe_n(txoe_n), .i_grant_enable(grant_en),
    .i_rx_frame(rx_frame), .o_link_bit_clock(bclk), .o_link_frame_sync(fsync),
    .o_link_rx_in(rxd), .o_d_channel_grant(grant), .o_tx_seen(tx_seen),
    .o_oe_seen(oe_seen), .o_frame_count(frame_count));

  // ----------------------------------------------------------------
  // Bus tasks and checkers
  // ----------------------------------------------------------------
  function automatic logic [3:0] ra(input int ch, input logic [1:0] idx);
    return {1'b0, 1'(ch), idx};
  endfunction : ra

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr

  // The note is queued before the strobe so the watcher always finds it
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge i_clk);
    rd_q.push_back(e);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
  endtask : rd

  task automatic fx(input logic [19:0] oe, input logic [19:0] tx, input logic [19:0] chk);
    fr_q.push_back({oe, tx, chk});
  endtask : fx

  task automatic wait_frames(input int n);
    repeat (n) @(frame_count);
  endtask : wait_frames

  task automatic stop_test;
    if (mismatches == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : stop_test

  // Read data stands only in the cycle after the strobe
  always @(posedge i_clk) begin
    if (rd_seen && rd_q.size() > 0) begin
      rd_exp = rd_q.pop_front();
      `CHK("read data", rd_exp, o_rdata)
    end
    rd_seen <= i_rd;
  end

  // Each finished frame is held against the oldest frame note
  always @(frame_count) begin
    if (fr_q.size() > 0) begin
      fe = fr_q.pop_front();
      `CHK("tx enable", fe.oe, oe_seen)
      `CHK("tx data", fe.tx & fe.chk, tx_seen & fe.chk)
    end
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin : main
    logic [7:0] d0, d1, rx8, ex;
    int         s;
    repeat (4) @(posedge i_clk);
    i_rst <= 1'b0;
    // Reset values, read-back and the unmapped hole
    for (int ch = 0; ch < 2; ch++) begin
      rd(ra(ch, `REG_CTRL), 8'h00);
      rd(ra(ch, `REG_MASK), 8'h00);
      rd(ra(ch, `REG_TX_DATA), 8'hFF);
    end
    wr(ra(0, `REG_MASK), 8'hA5);
    rd(ra(0, `REG_MASK), 8'hA5);
    wr(4'h8, 8'h5A);
    rd(4'h8, 8'h00);
    // Both bearers at once, on disjoint bits so the drivers never clash
    rx_frame <= 20'($random(seed));
    wr(ra(0, `REG_MASK), 8'h00);
    wr(ra(0, `REG_CTRL), 8'h11);
    wr(ra(1, `REG_CTRL), 8'h12);
    wait_frames(2);
    d0 = 8'($random(seed));
    d1 = 8'($random(seed));
    wr(ra(0, `REG_TX_DATA), d0);
    wr(ra(1, `REG_TX_DATA), d1);
    fx(20'h3_FCFF, 20'hF_FFFF, 20'h3_FCFF);
    fx(20'h3_FCFF, {2'b11, d1, 2'b11, d0}, 20'h3_FCFF);
    // One byte received so far: ready but no overrun yet
    rd(ra(0, `REG_CTRL), 8'h71);
    rd(ra(0, `REG_TX_DATA), d0);
    wait_frames(2);
    rd(ra(0, `REG_CTRL), 8'hD1);
    rd(ra(1, `REG_CTRL), 8'hD2);
    rd(ra(0, `REG_RX_DATA), rx_frame[7:0]);
    rd(ra(0, `REG_CTRL), 8'h11);
    rd(ra(1, `REG_RX_DATA), rx_frame[17:10]);
    // Subrate mask with floating, then driven-one, idle bits
    wait_frames(1);
    wr(ra(1, `REG_CTRL), 8'h00);
    wr(ra(0, `REG_MASK), 8'hF3);
    wr(ra(0, `REG_CTRL), 8'h11);
    fx(20'h0_000C, 20'h0_0000, 20'h0_0000);
    wait_frames(1);
    wr(ra(0, `REG_CTRL), 8'h19);
    fx(20'h0_00FF, 20'h0_00F3, 20'h0_00F3);
    // D-channel: transparent ignored, mask off, request then grant
    wait_frames(1);
    wr(ra(0, `REG_CTRL), 8'h00);
    wr(ra(1, `REG_MASK), 8'hF3);
    wr(ra(1, `REG_CTRL), 8'h17);
    repeat (3) @(posedge i_clk);
    `CHK("request idle", 1'b0, d_channel_request)
    fx(20'h0_0000, 20'h0_0000, 20'h0_0000);
    wr(ra(1, `REG_TX_DATA), 8'($random(seed)));
    repeat (3) @(posedge i_clk);
    `CHK("request", 1'b1, d_channel_request)
    wait_frames(1);
    grant_en <= 1'b1;
    fx(20'h4_0100, 20'h0_0000, 20'h0_0000);
    wait_frames(1);
    // Transparent receive through all eight alignments
    wr(ra(1, `REG_CTRL), 8'h00);
    grant_en <= 1'b0;
    rx8 = 8'($random(seed));
    rx_frame[7:0] <= rx8;
    wr(ra(0, `REG_CTRL), 8'h05);
    for (int z = 0; z < 8; z++) begin
      wr(ra(0, `REG_MASK), ~(8'h01 << z));
      wait_frames(3);
      s = (13 - z) % 8;
      for (int i = 0; i < 8; i++) begin
        ex[i] = rx8[(i + s) % 8];
      end
      rd(ra(0, `REG_RX_DATA), ex);
    end
    repeat (4) @(posedge i_clk);
    `CHK("notes left", 0, rd_q.size() + fr_q.size())
    stop_test();
  end

  // Watchdog sized well past the scenarios above
  initial begin : watchdog
    #400_000;
    mismatches++;
    stop_test();
  end
endmodule : isdn_tdm_slot_interface_tb
